//--- pkg/gcpm_pkg.sv
// constants for the global interface control and power management registers
// assumes a single 100 MHz system clock shared with the register access port
package gcpm_pkg;

  // register offsets on the internal register access port
  localparam logic [7:0] GCPM_ADDR_GLOBAL_IF   = 8'h0C;
  localparam logic [7:0] GCPM_ADDR_FACTORY     = 8'h0D;
  localparam logic [7:0] GCPM_ADDR_POWER_MODE  = 8'h0E;
  localparam logic [7:0] GCPM_ADDR_SLEEP_DELAY = 8'h0F;

  // field positions
  localparam int GCPM_CLK_SEL_LSB     = 4;
  localparam int GCPM_RESTORE_PRE_BIT = 2;
  localparam int GCPM_TAIL_TAG_BIT    = 1;
  localparam int GCPM_PASS_FC_BIT     = 0;
  localparam int GCPM_PLL_PD_BIT      = 5;
  localparam int GCPM_PM_MODE_LSB     = 3;

  // reset values
  localparam logic [1:0] GCPM_CLK_SEL_RST     = 2'h1;
  localparam logic       GCPM_RESTORE_PRE_RST = 1'h1;
  localparam logic       GCPM_TAIL_TAG_RST    = 1'h0;
  localparam logic       GCPM_PASS_FC_RST     = 1'h0;
  localparam logic       GCPM_PLL_PD_RST      = 1'h0;
  localparam logic [1:0] GCPM_PM_MODE_RST     = 2'h0;
  localparam logic [7:0] GCPM_SLEEP_DELAY_RST = 8'h50;
  localparam logic [7:0] GCPM_FACTORY_RST     = 8'h00;

  // management interface clock select codes
  localparam logic [1:0] GCPM_CLK_41M  = 2'h0;
  localparam logic [1:0] GCPM_CLK_83M  = 2'h1;
  localparam logic [1:0] GCPM_CLK_125M = 2'h2;
  localparam logic [1:0] GCPM_CLK_RSVD = 2'h3;

  // power management mode codes
  localparam logic [1:0] GCPM_PM_NORMAL = 2'h0;
  localparam logic [1:0] GCPM_PM_ENERGY = 2'h1;
  localparam logic [1:0] GCPM_PM_SOFT   = 2'h2;
  localparam logic [1:0] GCPM_PM_SAVING = 2'h3;

  // timing
  localparam int GCPM_CLK_FREQ_HZ      = 100_000_000;
  localparam int GCPM_SLEEP_UNIT_MS    = 20;
  localparam int GCPM_SLEEP_UNIT_CYCLES =
    GCPM_CLK_FREQ_HZ / 1000 * GCPM_SLEEP_UNIT_MS;
  localparam int GCPM_SOFT_SETTLE_CYCLES = 16;

  typedef enum logic [4:0]
  {
    GCPM_ST_NORMAL   = 5'h01,
    GCPM_ST_ED_AWAKE = 5'h02,
    GCPM_ST_ED_SLEEP = 5'h04,
    GCPM_ST_SOFT_OFF = 5'h08,
    GCPM_ST_SAVING   = 5'h10
  } gcpm_pstate_e;

endpackage

//--- src/gcpm_regs.sv
// global interface control, factory test and power management registers
// assumes register accesses arrive already decoded from the spi/smi engine,
// synchronous to I_CLK, and that strap and energy inputs are synchronous too
`timescale 1ns/100ps
`default_nettype none

module gcpm_regs
  import gcpm_pkg::*;
#(
  parameter int SLEEP_TICK_CYCLES = GCPM_SLEEP_UNIT_CYCLES
)
(
  input  wire logic       I_CLK,
  input  wire logic       I_RESET,
  input  wire logic [7:0] I_REG_ADDR,
  input  wire logic       I_REG_WR,
  input  wire logic [7:0] I_REG_WDATA,
  input  wire logic       I_REG_RD,
  output var  logic [7:0] O_REG_RDATA,
  output var  logic       O_REG_RVALID,
  output var  logic       O_REG_HIT,
  input  wire logic       I_STRAP_PM_N,
  input  wire logic       I_PORT5_10M,
  input  wire logic       I_ENERGY_PRESENT,
  output var  logic [1:0] O_MGMT_CLK_SEL,
  output var  logic       O_PORT5_RESTORE_PREAMBLE,
  output var  logic       O_PORT5_TAIL_TAG,
  output var  logic       O_PASS_FLOW_CTRL,
  output var  logic       O_PLL_PD_ENABLE,
  output var  logic       O_PM_NORMAL,
  output var  logic       O_PM_ENERGY_DETECT,
  output var  logic       O_PM_SOFT_OFF,
  output var  logic       O_PM_POWER_SAVING,
  output var  logic       O_LOW_POWER
);

  localparam logic [31:0] TICK_LAST = 32'(SLEEP_TICK_CYCLES - 1);
  localparam logic [4:0]  SETTLE_LAST = 5'(GCPM_SOFT_SETTLE_CYCLES - 1);

  logic [1:0]   clk_sel;
  logic         restore_pre;
  logic         tail_tag;
  logic         pass_fc;
  logic         pll_pd;
  logic [1:0]   pm_mode;
  logic [7:0]   sleep_delay;
  logic         strap_pending;
  logic         soft_pending;
  logic [4:0]   soft_cnt;
  logic [31:0]  tick_cnt;
  logic [7:0]   idle_ticks;
  logic         idle_reached;
  gcpm_pstate_e pstate;
  gcpm_pstate_e next_pstate;

  logic wr_global;
  logic wr_power;
  logic wr_sleep;
  logic rd_power;

  assign wr_global = I_REG_WR && (I_REG_ADDR == GCPM_ADDR_GLOBAL_IF);
  assign wr_power  = I_REG_WR && (I_REG_ADDR == GCPM_ADDR_POWER_MODE);
  assign wr_sleep  = I_REG_WR && (I_REG_ADDR == GCPM_ADDR_SLEEP_DELAY);
  assign rd_power  = I_REG_RD && (I_REG_ADDR == GCPM_ADDR_POWER_MODE);

  // global interface control: the reserved clock code is refused and the
  // previous speed kept, so the management engine never loses its clock
  always_ff @(posedge I_CLK or posedge I_RESET)
  begin
    if (I_RESET)
    begin
      clk_sel     <= GCPM_CLK_SEL_RST;
      restore_pre <= GCPM_RESTORE_PRE_RST;
      tail_tag    <= GCPM_TAIL_TAG_RST;
      pass_fc     <= GCPM_PASS_FC_RST;
    end
    else if (wr_global)
    begin
      if (I_REG_WDATA[GCPM_CLK_SEL_LSB +: 2] != GCPM_CLK_RSVD)
        clk_sel <= I_REG_WDATA[GCPM_CLK_SEL_LSB +: 2];
      restore_pre <= I_REG_WDATA[GCPM_RESTORE_PRE_BIT];
      tail_tag    <= I_REG_WDATA[GCPM_TAIL_TAG_BIT];
      pass_fc     <= I_REG_WDATA[GCPM_PASS_FC_BIT];
    end
  end

  always_ff @(posedge I_CLK or posedge I_RESET)
  begin
    if (I_RESET)
      pll_pd <= GCPM_PLL_PD_RST;
    else if (wr_power)
      pll_pd <= I_REG_WDATA[GCPM_PLL_PD_BIT];
  end

  always_ff @(posedge I_CLK or posedge I_RESET)
  begin
    if (I_RESET)
      sleep_delay <= GCPM_SLEEP_DELAY_RST;
    else if (wr_sleep)
      sleep_delay <= I_REG_WDATA;
  end

  // mode field: strap is sampled at the first edge after reset release,
  // since an asynchronous reset may only load a constant
  always_ff @(posedge I_CLK or posedge I_RESET)
  begin
    if (I_RESET)
    begin
      strap_pending <= 1'h1;
      pm_mode       <= GCPM_PM_MODE_RST;
    end
    else if (strap_pending)
    begin
      strap_pending <= 1'h0;
      pm_mode <= I_STRAP_PM_N ? GCPM_PM_NORMAL : GCPM_PM_ENERGY;
    end
    // a mode write in the last settle cycle replaces the pending request
    else if (soft_pending && !rd_power && !wr_power &&
             soft_cnt == SETTLE_LAST)
      pm_mode <= GCPM_PM_SOFT;
    else if (wr_power &&
             I_REG_WDATA[GCPM_PM_MODE_LSB +: 2] != GCPM_PM_SOFT)
      pm_mode <= I_REG_WDATA[GCPM_PM_MODE_LSB +: 2];
  end

  // soft off is held back for a settle window; a read of the mode register
  // inside the window cancels it, as the host is told to avoid read-back
  always_ff @(posedge I_CLK or posedge I_RESET)
  begin
    if (I_RESET)
    begin
      soft_pending <= 1'h0;
      soft_cnt     <= 5'h00;
    end
    else if (wr_power && !strap_pending)
    begin
      soft_pending <=
        (I_REG_WDATA[GCPM_PM_MODE_LSB +: 2] == GCPM_PM_SOFT);
      soft_cnt <= 5'h00;
    end
    else if (soft_pending)
    begin
      if (rd_power || soft_cnt == SETTLE_LAST)
        soft_pending <= 1'h0;
      soft_cnt <= soft_cnt + 5'h01;
    end
  end

  // idle timer: the unit divider restarts whenever energy is seen, so a
  // counted unit is always a full unit of continuous silence
  always_ff @(posedge I_CLK or posedge I_RESET)
  begin
    if (I_RESET)
    begin
      tick_cnt   <= 32'h00000000;
      idle_ticks <= 8'h00;
    end
    else if (I_ENERGY_PRESENT || pm_mode != GCPM_PM_ENERGY)
    begin
      tick_cnt   <= 32'h00000000;
      idle_ticks <= 8'h00;
    end
    else if (tick_cnt == TICK_LAST)
    begin
      tick_cnt <= 32'h00000000;
      if (idle_ticks != 8'hFF)
        idle_ticks <= idle_ticks + 8'h01;
    end
    else
      tick_cnt <= tick_cnt + 32'h00000001;
  end

  assign idle_reached = (idle_ticks >= sleep_delay) && !I_ENERGY_PRESENT;

  always_comb
  begin
    next_pstate = pstate;
    unique case (pstate)
      GCPM_ST_NORMAL,
      GCPM_ST_SOFT_OFF,
      GCPM_ST_SAVING:
      begin
        unique case (pm_mode)
          GCPM_PM_NORMAL: next_pstate = GCPM_ST_NORMAL;
          GCPM_PM_ENERGY: next_pstate = GCPM_ST_ED_AWAKE;
          GCPM_PM_SOFT:   next_pstate = GCPM_ST_SOFT_OFF;
          GCPM_PM_SAVING: next_pstate = GCPM_ST_SAVING;
        endcase
      end
      GCPM_ST_ED_AWAKE:
      begin
        if (pm_mode != GCPM_PM_ENERGY)
          next_pstate = GCPM_ST_NORMAL;
        else if (idle_reached)
          next_pstate = GCPM_ST_ED_SLEEP;
      end
      GCPM_ST_ED_SLEEP:
      begin
        if (pm_mode != GCPM_PM_ENERGY || I_ENERGY_PRESENT)
          next_pstate = GCPM_ST_ED_AWAKE;
      end
      default: next_pstate = GCPM_ST_NORMAL;
    endcase
  end

  always_ff @(posedge I_CLK or posedge I_RESET)
  begin
    if (I_RESET)
      pstate <= GCPM_ST_NORMAL;
    else
      pstate <= next_pstate;
  end

  // mode outputs follow the state register one edge later
  always_ff @(posedge I_CLK or posedge I_RESET)
  begin
    if (I_RESET)
    begin
      O_PM_NORMAL        <= 1'h1;
      O_PM_ENERGY_DETECT <= 1'h0;
      O_PM_SOFT_OFF      <= 1'h0;
      O_PM_POWER_SAVING  <= 1'h0;
      O_LOW_POWER        <= 1'h0;
    end
    else
    begin
      O_PM_NORMAL        <= (pstate == GCPM_ST_NORMAL);
      O_PM_ENERGY_DETECT <= (pstate == GCPM_ST_ED_AWAKE) ||
                            (pstate == GCPM_ST_ED_SLEEP);
      O_PM_SOFT_OFF      <= (pstate == GCPM_ST_SOFT_OFF);
      O_PM_POWER_SAVING  <= (pstate == GCPM_ST_SAVING);
      O_LOW_POWER        <= (pstate == GCPM_ST_ED_SLEEP);
    end
  end

  // control outputs are registered from the fields; restore preamble is gated by I_PORT5_10M and the pll bit is inverted
  always_ff @(posedge I_CLK or posedge I_RESET)
  begin
    if (I_RESET)
    begin
      O_MGMT_CLK_SEL           <= GCPM_CLK_SEL_RST;
      O_PORT5_RESTORE_PREAMBLE <= 1'h0;
      O_PORT5_TAIL_TAG         <= GCPM_TAIL_TAG_RST;
      O_PASS_FLOW_CTRL         <= GCPM_PASS_FC_RST;
      O_PLL_PD_ENABLE          <= 1'h0;
    end
    else
    begin
      O_MGMT_CLK_SEL           <= clk_sel;
      O_PORT5_RESTORE_PREAMBLE <= restore_pre && I_PORT5_10M;
      O_PORT5_TAIL_TAG         <= tail_tag;
      O_PASS_FLOW_CTRL         <= pass_fc;
      O_PLL_PD_ENABLE          <= !pll_pd;
    end
  end

  // read port: data one edge after the strobe; unmapped offsets answer zero
  always_ff @(posedge I_CLK or posedge I_RESET)
  begin
    if (I_RESET)
    begin
      O_REG_RDATA  <= 8'h00;
      O_REG_RVALID <= 1'h0;
      O_REG_HIT    <= 1'h0;
    end
    else
    begin
      O_REG_RVALID <= I_REG_RD;
      O_REG_HIT    <= 1'h0;
      O_REG_RDATA  <= 8'h00;
      if (I_REG_RD)
      begin
        unique case (I_REG_ADDR)
          GCPM_ADDR_GLOBAL_IF:
          begin
            O_REG_HIT   <= 1'h1;
            O_REG_RDATA <= {2'h0, clk_sel, 1'h0, restore_pre, tail_tag,
                            pass_fc};
          end
          GCPM_ADDR_FACTORY:
          begin
            O_REG_HIT   <= 1'h1;
            O_REG_RDATA <= GCPM_FACTORY_RST;
          end
          GCPM_ADDR_POWER_MODE:
          begin
            O_REG_HIT   <= 1'h1;
            O_REG_RDATA <= {2'h0, pll_pd, pm_mode, 3'h0};
          end
          GCPM_ADDR_SLEEP_DELAY:
          begin
            O_REG_HIT   <= 1'h1;
            O_REG_RDATA <= sleep_delay;
          end
          default:
          begin
            O_REG_HIT   <= 1'h0;
            O_REG_RDATA <= 8'h00;
          end
        endcase
      end
    end
  end

endmodule

`default_nettype wire

//--- test/gcpm_host.sv
// host model: single pre-decoded register reads and writes
// drives just after I_CLK rises; one access at a time
`timescale 1ns/100ps
`default_nettype none
module gcpm_host
(
  input  wire logic       i_clk,
  input  wire logic [7:0] i_rdata,
  input  wire logic       i_rvalid,
  input  wire logic       i_hit,
  output var  logic [7:0] o_addr,
  output var  logic [7:0] o_wdata,
  output var  logic       o_wr,
  output var  logic       o_rd
);
  initial
  begin
    o_addr = 8'h00;
    o_wdata = 8'h00;
    o_wr = 1'b0;
    o_rd = 1'b0;
  end
  // no serial link here, so the host clock limit holds by construction
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge i_clk);
    #1;
    o_addr = a;
    o_wdata = d;
    o_wr = 1'b1;
    @(posedge i_clk);
    #1;
    o_wr = 1'b0;
    // released lines show the inverse, not a stale copy
    o_addr = ~a;
    o_wdata = ~d;
  endtask
  // a read of the mode register may cancel soft off; bench decides
  task automatic rd(input logic [7:0] a, output logic [7:0] d,
                    output logic [1:0] vh);
    @(posedge i_clk);
    #1;
    o_addr = a;
    o_rd = 1'b1;
    @(posedge i_clk);
    #1;
    // answer stands until the next edge; taken here, clear of that edge
    d = i_rdata;
    vh = {i_rvalid, i_hit};
    o_rd = 1'b0;
    o_addr = ~a;
  endtask
endmodule
`default_nettype wire

//--- test/gcpm_regs_assertions.sv
// port-level checks on gcpm_regs
// bound into gcpm_regs; the sleep tick count is handed on by the bind
`timescale 1ns/100ps
`default_nettype none
module gcpm_regs_assertions
  import gcpm_pkg::*;
#(
  parameter int SLEEP_TICK_CYCLES = 10
)
(
  input wire logic       I_CLK,
  input wire logic       I_RESET,
  input wire logic [7:0] I_REG_ADDR,
  input wire logic       I_REG_WR,
  input wire logic [7:0] I_REG_WDATA,
  input wire logic       I_REG_RD,
  input wire logic [7:0] O_REG_RDATA,
  input wire logic       O_REG_RVALID,
  input wire logic       O_REG_HIT,
  input wire logic       I_PORT5_10M,
  input wire logic       I_ENERGY_PRESENT,
  input wire logic [1:0] O_MGMT_CLK_SEL,
  input wire logic       O_PORT5_RESTORE_PREAMBLE,
  input wire logic       O_PORT5_TAIL_TAG,
  input wire logic       O_PASS_FLOW_CTRL,
  input wire logic       O_PLL_PD_ENABLE,
  input wire logic       O_PM_SOFT_OFF,
  input wire logic       O_LOW_POWER
);
  default clocking @(posedge I_CLK);
  endclocking
  default disable iff (I_RESET);
  logic [7:0]  delay;
  logic [31:0] low_cnt;
  wire logic   w_if = I_REG_WR && I_REG_ADDR == GCPM_ADDR_GLOBAL_IF;
  wire logic   w_pm = I_REG_WR && I_REG_ADDR == GCPM_ADDR_POWER_MODE;
  wire logic   r_pm = I_REG_RD && I_REG_ADDR == GCPM_ADDR_POWER_MODE;
  // shadow of the delay field, the register itself is not visible here
  always_ff @(posedge I_CLK or posedge I_RESET)
    if (I_RESET)
      delay <= GCPM_SLEEP_DELAY_RST;
    else if (I_REG_WR && I_REG_ADDR == GCPM_ADDR_SLEEP_DELAY)
      delay <= I_REG_WDATA;
  always_ff @(posedge I_CLK or posedge I_RESET)
    if (I_RESET)
      low_cnt <= '0;
    else if (I_ENERGY_PRESENT)
      low_cnt <= '0;
    else
      low_cnt <= low_cnt + 32'h1;
  sequence s_soft_req;
    w_pm && I_REG_WDATA[4:3] == GCPM_PM_SOFT;
  endsequence
  sequence s_quiet;
    !(w_pm || r_pm);
  endsequence
  a_clk_sel_take: assert property (
    w_if && I_REG_WDATA[5:4] != GCPM_CLK_RSVD
    |-> ##3 O_MGMT_CLK_SEL == $past(I_REG_WDATA[5:4], 3))
    else $error("clock select not taken");
  a_clk_rsvd_kept: assert property (
    w_if && I_REG_WDATA[5:4] == GCPM_CLK_RSVD
    |-> ##3 O_MGMT_CLK_SEL == $past(O_MGMT_CLK_SEL, 3))
    else $error("reserved clock code taken");
  a_tag_fc_copy: assert property (
    w_if |-> ##3
    {O_PORT5_TAIL_TAG, O_PASS_FLOW_CTRL} == $past(I_REG_WDATA[1:0], 3))
    else $error("tag or flow bit wrong");
  a_restore_gate: assert property (
    O_PORT5_RESTORE_PREAMBLE |-> $past(I_PORT5_10M))
    else $error("restore outside 10M");
  a_pll_pd_sense: assert property (
    w_pm && I_REG_WDATA[4:3] != GCPM_PM_SOFT
    |-> ##3 O_PLL_PD_ENABLE == !$past(I_REG_WDATA[5], 3))
    else $error("pll power-down sense wrong");
  a_soft_off_entry: assert property (
    s_soft_req ##1 s_quiet [*8] ##1 s_quiet [*8]
    |-> ##[1:4] O_PM_SOFT_OFF)
    else $error("soft off not entered");
  a_factory_zero: assert property (
    I_REG_RD && I_REG_ADDR == GCPM_ADDR_FACTORY |=> O_REG_RVALID
    && O_REG_HIT && O_REG_RDATA == GCPM_FACTORY_RST)
    else $error("factory register not zero");
  a_sleep_min_wait: assert property (
    $rose(O_LOW_POWER) |-> low_cnt > delay * SLEEP_TICK_CYCLES)
    else $error("sleep entered too early");
endmodule
bind gcpm_regs gcpm_regs_assertions #(
  .SLEEP_TICK_CYCLES(SLEEP_TICK_CYCLES)
) u_gcpm_chk (.*);
`default_nettype wire

//--- test/gcpm_regs_tb.sv
// self-checking bench for gcpm_regs over its register port
// host model drives the port; the checker is bound into the design
`timescale 1ns/100ps
`default_nettype none
module gcpm_regs_tb
  import gcpm_pkg::*;
;
  localparam int         n_tick = 10;
  localparam logic [7:0] rv [5] = '{8'h14, 8'h00, 8'h00, 8'h50, 8'h00};
  localparam logic [1:0] ms [3] = '{2'h3, 2'h1, 2'h0};
  logic       I_CLK = 1'b0;
  logic       I_RESET = 1'b1;
  logic       I_STRAP_PM_N = 1'b1;
  logic       I_PORT5_10M = 1'b1;
  logic       I_ENERGY_PRESENT = 1'b1;
  logic [7:0] I_REG_ADDR, I_REG_WDATA, O_REG_RDATA, e, ev;
  logic [1:0] O_MGMT_CLK_SEL, vh, cc, k;
  logic       I_REG_WR, I_REG_RD, O_REG_RVALID, O_REG_HIT, pb;
  logic       O_PORT5_RESTORE_PREAMBLE, O_PORT5_TAIL_TAG, O_PASS_FLOW_CTRL;
  logic       O_PLL_PD_ENABLE, O_PM_NORMAL, O_PM_ENERGY_DETECT;
  logic       O_PM_SOFT_OFF, O_PM_POWER_SAVING, O_LOW_POWER;
  int         bad_count = 0;
  int         n_compared = 0;
  int         cycles = 0;
  int         n;
  wire logic [7:0] pm = {4'h0, O_PM_POWER_SAVING, O_PM_SOFT_OFF,
                         O_PM_ENERGY_DETECT, O_PM_NORMAL};
  wire logic [7:0] outs = {O_MGMT_CLK_SEL, O_PORT5_RESTORE_PREAMBLE,
    O_PORT5_TAIL_TAG, O_PASS_FLOW_CTRL, O_PLL_PD_ENABLE, O_LOW_POWER, 1'b0};
  gcpm_regs #(.SLEEP_TICK_CYCLES(n_tick)) DUT (.*);
  gcpm_host host (.i_clk(I_CLK), .i_rdata(O_REG_RDATA),
    .i_rvalid(O_REG_RVALID), .i_hit(O_REG_HIT), .o_addr(I_REG_ADDR),
    .o_wdata(I_REG_WDATA), .o_wr(I_REG_WR), .o_rd(I_REG_RD));
  always #5 I_CLK = ~I_CLK;
  always @(posedge I_CLK)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      bad_count++;
      summarize();
    end
  end
  task automatic tick(int t);
    repeat (t) @(posedge I_CLK);
    #1;
  endtask
  task automatic rst(logic s);
    I_RESET = 1'b1;
    I_STRAP_PM_N = s;
    tick(10);
    I_RESET = 1'b0;
    tick(2);
  endtask
  task automatic chk(string s, logic [7:0] x, logic [7:0] g);
    n_compared++;
    if (g !== x)
    begin
      $display("ERROR %s expected %h seen %h", s, x, g);
      bad_count++;
    end
  endtask
  task automatic rdchk(logic [7:0] a, logic [7:0] x, logic [1:0] v);
    host.rd(a, ev, vh);
    chk("read data", x, ev);
    chk("valid hit", {6'h00, v}, {6'h00, vh});
  endtask
  task automatic summarize();
    $display("compared %0d mismatched %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial
  begin
    rst(1'b1);
    for (int i = 0; i < 5; i++)
      rdchk(8'h0C + 8'(i), rv[i], {1'b1, i < 4});
    chk("outputs", 8'h64, outs);
    chk("mode", 8'h01, pm);
    $display("reset test done");
    k = GCPM_CLK_83M;
    for (int c = 0; c < 4; c++)
    begin
      cc = 2'(c);
      host.wr(GCPM_ADDR_GLOBAL_IF,
              {2'h3, cc, 1'b1, cc[0], cc[1], ~cc[0]});
      if (cc != GCPM_CLK_RSVD)
        k = cc;
      e = {2'h0, k, 1'b0, cc[0], cc[1], ~cc[0]};
      rdchk(GCPM_ADDR_GLOBAL_IF, e, 2'h3);
      e = {k, cc[0], cc[1], ~cc[0], 3'h4};
      chk("outputs", e, outs);
    end
    tick(1);
    I_PORT5_10M = 1'b0;
    tick(3);
    chk("restore gate", 8'h00, outs & 8'h20);
    host.wr(GCPM_ADDR_FACTORY, 8'hFF);
    rdchk(GCPM_ADDR_FACTORY, 8'h00, 2'h3);
    $display("control test done");
    for (int i = 0; i < 3; i++)
    begin
      pb = i[0];
      host.wr(GCPM_ADDR_POWER_MODE, {2'h3, pb, ms[i], 3'h7});
      rdchk(GCPM_ADDR_POWER_MODE, {2'h0, pb, ms[i], 3'h0}, 2'h3);
      tick(2);
      chk("mode", {4'h0, 4'h1 << ms[i]}, pm);
      chk("pll", {7'h00, ~pb}, {7'h00, O_PLL_PD_ENABLE});
    end
    host.wr(GCPM_ADDR_POWER_MODE, 8'h10);
    rdchk(GCPM_ADDR_POWER_MODE, 8'h00, 2'h3);
    tick(20);
    chk("cancelled", 8'h01, pm);
    host.wr(GCPM_ADDR_POWER_MODE, 8'h10);
    tick(20);
    chk("soft off", 8'h04, pm);
    $display("mode test done");
    host.wr(GCPM_ADDR_SLEEP_DELAY, 8'h03);
    host.wr(GCPM_ADDR_POWER_MODE, 8'h08);
    rdchk(GCPM_ADDR_SLEEP_DELAY, 8'h03, 2'h3);
    tick(3);
    I_ENERGY_PRESENT = 1'b0;
    n = 0;
    while (O_LOW_POWER !== 1'b1 && n < 100)
    begin
      tick(1);
      n++;
    end
    chk("sleep wait", 8'(3 * n_tick + 2), 8'(n));
    I_ENERGY_PRESENT = 1'b1;
    tick(3);
    chk("wake", 8'h00, outs & 8'h02);
    $display("sleep test done");
    rst(1'b0);
    tick(3);
    chk("strap mode", 8'h02, pm);
    rdchk(GCPM_ADDR_POWER_MODE, 8'h08, 2'h3);
    $display("strap test done");
    summarize();
  end
endmodule
`default_nettype wire
